/* File: rtl/card_timing_pkg.sv */
// Purpose: constants for the card cycle timing generator
// Assumes: one clock, counts in clock periods of that clock
// Notes: register offsets are byte addresses on a 32-bit bus
package card_timing_pkg;

   // ==========================================================
   // interval counts, clock periods
   localparam logic [7:0] SETUP_IO = 8'h03;
   localparam logic [7:0] SETUP_MEM_LO = 8'h02;
   localparam logic [7:0] SETUP_MEM_HI = 8'h04;
   localparam logic [7:0] HOLD_IO = 8'h02;
   localparam logic [7:0] HOLD_MEM_LO = 8'h02;
   localparam logic [7:0] HOLD_MEM_HI = 8'h03;
   localparam logic [7:0] SETUP_EXTRA = 8'h02;
   localparam logic [7:0] HOLD_EXTRA = 8'h01;
   localparam logic [7:0] ACT8_NOWS = 8'h13;
   localparam logic [7:0] ACT8_WS = 8'h17;
   localparam logic [7:0] ACT8_ZWS = 8'h07;
   localparam logic [7:0] ACT16_IO_NOWS = 8'h07;
   localparam logic [7:0] ACT16_IO_WS = 8'h0b;
   localparam logic [7:0] ACT16_MEM_00 = 8'h09;
   localparam logic [7:0] ACT16_MEM_01 = 8'h0d;
   localparam logic [7:0] ACT16_MEM_10 = 8'h11;
   localparam logic [7:0] ACT16_MEM_11 = 8'h15;
   localparam logic [7:0] ACT16_MEM_ZWS = 8'h05;

   // ==========================================================
   // register map, byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   // control fields
   localparam int CTRL_START = 0;
   localparam int CTRL_IO = 1;
   localparam int CTRL_WIDE = 2;
   localparam int CTRL_WRITE = 3;
   localparam int CTRL_ZWS = 4;
   localparam int CTRL_WS_LO = 5;
   localparam int CTRL_WS_HI = 6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_ACTIVE = 3'b010,
      ST_WAIT = 3'b011,
      ST_HOLD = 3'b100
   } cyc_state_t;

endpackage

/* File: rtl/interval_select.sv */
// Purpose: pick setup, active and hold counts for one card cycle
// Assumes: window settings stable while a cycle runs
// Notes: purely combinational
`timescale 1ns/1ps
module interval_select (
   input wire logic is_io_i,
   input wire logic wide_i,
   input wire logic zero_wait_i,
   input wire logic [1:0] wait_state_select_i,
   output logic [7:0] setup_o,
   output logic [7:0] active_o,
   output logic [7:0] hold_o
);
   import card_timing_pkg::*;

   logic wait_state_upper_bit;
   logic any_ws;
   assign wait_state_upper_bit = wait_state_select_i[1];
   assign any_ws = is_io_i ? wait_state_select_i[0]
                           : (wait_state_select_i != 2'b00);

   always_comb begin
      if (is_io_i) begin
         setup_o = SETUP_IO;
      end else if (wait_state_upper_bit) begin
         setup_o = SETUP_MEM_HI;
      end else begin
         setup_o = SETUP_MEM_LO;
      end
   end

   always_comb begin
      if (is_io_i) begin
         hold_o = HOLD_IO;
      end else if (wait_state_upper_bit) begin
         hold_o = HOLD_MEM_HI;
      end else begin
         hold_o = HOLD_MEM_LO;
      end
   end

   always_comb begin
      if (!wide_i) begin
         if (any_ws) begin
            active_o = ACT8_WS;
         end else if (zero_wait_i) begin
            active_o = ACT8_ZWS;
         end else begin
            active_o = ACT8_NOWS;
         end
      end else if (is_io_i) begin
         active_o = any_ws ? ACT16_IO_WS : ACT16_IO_NOWS;
      end else begin
         case (wait_state_select_i)
            2'b00: active_o = zero_wait_i ? ACT16_MEM_ZWS : ACT16_MEM_00;
            2'b01: active_o = ACT16_MEM_01;
            2'b10: active_o = ACT16_MEM_10;
            default: active_o = ACT16_MEM_11;
         endcase
      end
   end

endmodule // interval_select

/* File: rtl/card_cycle_gen.sv */
// Purpose: card cycle generator timed in clock periods
// Assumes: classic wishbone slave, card wait input synchronous
// Notes: software starts a cycle by writing the control register
`timescale 1ns/1ps

module card_cycle_gen (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic card_wait_n_i,
   output logic addr_valid_o,
   output logic strobe_n_o,
   output logic busy_o,
   output logic done_o
);
   import card_timing_pkg::*;

   // ==========================================================
   // bus slave
   logic ack_q;
   logic [31:0] ctrl_q;
   logic [7:0] done_cnt_q;
   logic req;
   logic wr_ctrl;
   logic start;
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_ctrl = req && wb_we_i && (wb_adr_i == ADDR_CTRL);
   assign start = wr_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_START];
   assign wb_ack_o = ack_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // per-byte lane write of the control word; start bit self clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
               ctrl_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
         end
         ctrl_q[CTRL_START] <= 1'b0;
      end
   end

   cyc_state_t state_q;
   logic [7:0] cnt_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && wb_adr_i == ADDR_CTRL) begin
         wb_dat_o <= ctrl_q;
      end else if (req && wb_adr_i == ADDR_STAT) begin
         wb_dat_o <= {13'h0000, state_q, cnt_q, done_cnt_q};
      end else begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // interval selection, latched at start
   logic [7:0] sel_setup;
   logic [7:0] sel_active;
   logic [7:0] sel_hold;
   logic [7:0] active_q;
   logic [7:0] hold_q;
   logic io_q;

   interval_select u_sel (
      .is_io_i(wb_dat_i[CTRL_IO]),
      .wide_i(wb_dat_i[CTRL_WIDE]),
      .zero_wait_i(wb_dat_i[CTRL_ZWS]),
      .wait_state_select_i(wb_dat_i[CTRL_WS_HI:CTRL_WS_LO]),
      .setup_o(sel_setup),
      .active_o(sel_active),
      .hold_o(sel_hold)
   );

   // ==========================================================
   // cycle sequencer
   // interval counting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= 8'h00;
         active_q <= 8'h00;
         hold_q <= 8'h00;
         io_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  io_q <= wb_dat_i[CTRL_IO];
                  active_q <= sel_active;
                  if (wb_dat_i[CTRL_IO]) begin
                     cnt_q <= sel_setup;
                     hold_q <= sel_hold;
                  end else begin
                     cnt_q <= sel_setup + SETUP_EXTRA;
                     hold_q <= sel_hold + HOLD_EXTRA;
                  end
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_q == 8'h01) begin
                  cnt_q <= active_q;
                  state_q <= ST_ACTIVE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            ST_ACTIVE: begin
               if (cnt_q == 8'h01) begin
                  if (card_wait_n_i) begin
                     cnt_q <= hold_q;
                     state_q <= ST_HOLD;
                  end else begin
                     state_q <= ST_WAIT;
                  end
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            ST_WAIT: begin
               if (card_wait_n_i) begin
                  cnt_q <= hold_q;
                  state_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt_q == 8'h01) begin
                  cnt_q <= 8'h00;
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // completion counter shows progress to software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_cnt_q <= 8'h00;
         done_o <= 1'b0;
      end else begin
         done_o <= (state_q == ST_HOLD) && (cnt_q == 8'h01);
         if ((state_q == ST_HOLD) && (cnt_q == 8'h01)) begin
            done_cnt_q <= done_cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_valid_o <= 1'b0;
         strobe_n_o <= 1'b1;
      end else begin
         // address drops with the last hold count, not a clock later
         if (state_q == ST_IDLE) begin
            addr_valid_o <= start;
         end else begin
            addr_valid_o <= !(state_q == ST_HOLD && cnt_q == 8'h01);
         end
         strobe_n_o <= !((state_q == ST_SETUP && cnt_q == 8'h01)
                        || (state_q == ST_ACTIVE && !(cnt_q == 8'h01
                            && card_wait_n_i))
                        || (state_q == ST_WAIT && !card_wait_n_i));
      end
   end
   assign busy_o = (state_q != ST_IDLE);

   // ==========================================================
   // checks
   property p_strobe_wait;
      @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_WAIT && !card_wait_n_i) |=> !strobe_n_o;
   endproperty
   a_strobe_wait: assert property (p_strobe_wait)
      else $error("strobe released while card waits");

   property p_io_setup;
      @(posedge clk_i) disable iff (rst_i)
      (start && state_q == ST_IDLE && wb_dat_i[CTRL_IO]) |=>
         (cnt_q == SETUP_IO);
   endproperty
   a_io_setup: assert property (p_io_setup)
      else $error("io setup count wrong");

   logic [7:0] sel_setup_q;
   logic [7:0] sel_hold_q;
   always_ff @(posedge clk_i) begin
      sel_setup_q <= sel_setup;
      sel_hold_q <= sel_hold;
   end

   property p_mem_setup;
      @(posedge clk_i) disable iff (rst_i)
      (start && state_q == ST_IDLE && !wb_dat_i[CTRL_IO]) |=>
         (cnt_q == sel_setup_q + SETUP_EXTRA);
   endproperty
   a_mem_setup: assert property (p_mem_setup)
      else $error("memory setup margin missing");

   property p_hold_margin;
      @(posedge clk_i) disable iff (rst_i)
      (start && state_q == ST_IDLE && !wb_dat_i[CTRL_IO]) |=>
         (hold_q == sel_hold_q + HOLD_EXTRA);
   endproperty
   a_hold_margin: assert property (p_hold_margin)
      else $error("memory hold margin missing");

   property p_setup_to_active;
      @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_SETUP && cnt_q == 8'h01) |=>
         (state_q == ST_ACTIVE && cnt_q == active_q);
   endproperty
   a_setup_to_active: assert property (p_setup_to_active)
      else $error("active count not loaded");

   property p_addr_during;
      @(posedge clk_i) disable iff (rst_i)
      $fell(strobe_n_o) |-> addr_valid_o;
   endproperty
   a_addr_during: assert property (p_addr_during)
      else $error("strobe without address");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");

   property p_wait_release;
      @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_WAIT && card_wait_n_i) |=> (state_q == ST_HOLD);
   endproperty
   a_wait_release: assert property (p_wait_release)
      else $error("no hold after wait release");

   property p_active_to_hold;
      @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_ACTIVE && cnt_q == 8'h01 && card_wait_n_i) |=>
         (state_q == ST_HOLD && cnt_q == hold_q && strobe_n_o);
   endproperty
   a_active_to_hold: assert property (p_active_to_hold)
      else $error("hold count not loaded");

   property p_hold_end;
      @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_HOLD && cnt_q == 8'h01) |=>
         (state_q == ST_IDLE && !addr_valid_o && done_o);
   endproperty
   a_hold_end: assert property (p_hold_end)
      else $error("address held past hold count");

   property p_idle_strobe;
      @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_IDLE) |=> strobe_n_o;
   endproperty
   a_idle_strobe: assert property (p_idle_strobe)
      else $error("strobe low outside a cycle");

   property p_io_hold;
      @(posedge clk_i) disable iff (rst_i)
      (start && state_q == ST_IDLE && wb_dat_i[CTRL_IO]) |=>
         (hold_q == HOLD_IO);
   endproperty
   a_io_hold: assert property (p_io_hold)
      else $error("io hold count wrong");

   property p_done_pulse;
      @(posedge clk_i) disable iff (rst_i)
      done_o |=> !done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done longer than one cycle");

   c_start_io: cover property (@(posedge clk_i) start && wb_dat_i[CTRL_IO]);
   c_start_mem: cover property (@(posedge clk_i) start && !wb_dat_i[CTRL_IO]);
   c_waited: cover property (@(posedge clk_i) state_q == ST_WAIT);
   c_done: cover property (@(posedge clk_i) done_o);

endmodule // card_cycle_gen

/* File: testbench/card_wait_model.sv */
// Purpose: card side model that drives the wait line
// Assumes: the device samples wait on the rising clock edge
// Notes: wait is pulled up whenever no stretch is asked for
`timescale 1ns/1ps
module card_wait_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic strobe_n_i,
   input wire logic [7:0] stall_i,
   output logic card_wait_n_o
);
   logic [7:0] cnt_q;
   // ==========================================================
   // wait low stretches strobe
   always_ff @(posedge clk_i) begin
      if (rst_i || strobe_n_i) begin
         cnt_q <= 8'h00;
         card_wait_n_o <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         card_wait_n_o <= (cnt_q + 8'h01) >= stall_i;
      end
   end
endmodule // card_wait_model

/* File: testbench/test_card_cycle_gen.sv */
// Purpose: self-checking bench for the card cycle generator
// Assumes: one wishbone master, card model on the wait line
// Notes: interval lengths are counted at the card side pins
`timescale 1ns/1ps
module test_card_cycle_gen;
   import card_timing_pkg::*;
   typedef struct {logic [7:0] s, a, h, w;} note_t;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, card_wait_n_i, addr_valid_o, strobe_n_o, busy_o, done_o;
   logic [7:0] stall = 8'h00, n_cyc = 8'h00, s = 0, a = 0, h = 0;
   logic [15:0] lfsr_q = 16'h862e;
   note_t q[$];
   note_t e, m;
   int n_mismatch = 0, checks = 0;
   card_cycle_gen uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .card_wait_n_i(card_wait_n_i),
      .addr_valid_o(addr_valid_o), .strobe_n_o(strobe_n_o),
      .busy_o(busy_o), .done_o(done_o));
   card_wait_model card (.clk_i(clk_i), .rst_i(rst_i),
      .strobe_n_i(strobe_n_o), .stall_i(stall),
      .card_wait_n_o(card_wait_n_i));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, got,
                      input bit atleast);
      checks++;
      if ((atleast ? (got < ex) : (got !== ex)) !== 1'b0) begin
         n_mismatch++;
         $display("FAIL %s expected %0d seen %0d", nm, ex, got);
      end
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [3:0] ad,
                     input logic [31:0] d, input logic [3:0] sl);
      int i;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= sl;
      wb_adr_i <= ad;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      if (wb_ack_o !== 1'b1) begin
         n_mismatch++;
         summarize();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic note_t expect_of(input logic [6:0] c);
      note_t n;
      logic [1:0] ws;
      logic io, any;
      ws = c[6:5];
      io = c[1];
      any = io ? ws[0] : (ws != 2'b00);
      n.s = io ? SETUP_IO : (ws[1] ? SETUP_MEM_HI : SETUP_MEM_LO) + SETUP_EXTRA;
      n.h = io ? HOLD_IO : (ws[1] ? HOLD_MEM_HI : HOLD_MEM_LO) + HOLD_EXTRA;
      n.w = 8'h00;
      if (!c[2])
         n.a = (c[4] && !any) ? ACT8_ZWS : (any ? ACT8_WS : ACT8_NOWS);
      else if (io)
         n.a = ws[0] ? ACT16_IO_WS : ACT16_IO_NOWS;
      else if (c[4] && ws == 2'b00)
         n.a = ACT16_MEM_ZWS;
      else if (ws[1])
         n.a = ws[0] ? ACT16_MEM_11 : ACT16_MEM_10;
      else
         n.a = ws[0] ? ACT16_MEM_01 : ACT16_MEM_00;
      return n;
   endfunction
   // ==========================================================
   // monitor: count setup, strobe low and hold at the pins
   always @(posedge clk_i) begin
      if (addr_valid_o === 1'b1) begin
         if (strobe_n_o === 1'b0)
            a = a + 1;
         else if (a == 0)
            s = s + 1;
         else
            h = h + 1;
      end else if (s != 0) begin
         m = q.pop_front();
         chk("setup", m.s, s, 0);
         chk("active", m.w != 0 ? m.w : m.a, a, m.w != 0);
         chk("hold", m.h, h, 0);
         chk("done", 1, done_o, 0);
         s = 0;
         a = 0;
         h = 0;
      end
   end
   // ==========================================================
   // driver: every window setting, then random ones
   initial begin
      logic [6:0] c;
      int i;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int k = 0; k < 40; k++) begin
         lfsr_q = lfsr(lfsr_q);
         c = (k < 32) ? {k[4:2], lfsr_q[0], k[1:0], 1'b1}
                      : {lfsr_q[6:1], 1'b1};
         e = expect_of(c);
         // a stalling card must stretch the strobe
         if (k == 5)
            e.w = e.a + 8'h02;
         stall <= (k == 5) ? e.a + 8'h03 : 8'h00;
         q.push_back(e);
         n_cyc++;
         wb(1'b1, ADDR_CTRL, 32'(c), 4'hf);
         // a start while busy is dropped
         if (k == 7)
            wb(1'b1, ADDR_CTRL, 32'(c), 4'hf);
         for (i = 0; i < 300 && busy_o !== 1'b0; i++)
            @(posedge clk_i);
         chk("busy", 0, busy_o, 0);
         if (busy_o !== 1'b0)
            summarize();
         repeat (3) @(posedge clk_i);
      end
      // byte lane 0 off: no start, lane 1 still lands
      wb(1'b1, ADDR_CTRL, 32'h0000_1201, 4'he);
      chk("lane start", 0, busy_o, 0);
      wb(1'b0, ADDR_CTRL, 32'h0000_0000, 4'hf);
      chk("lane write", 32'h0000_0012, rd[31:8], 0);
      wb(1'b0, ADDR_STAT, 32'h0000_0000, 4'hf);
      chk("done count", n_cyc, rd[7:0], 0);
      wb(1'b0, 4'h8, 32'h0000_0000, 4'hf);
      chk("unmapped", 0, rd, 0);
      chk("pending", 0, q.size(), 0);
      summarize();
   end
endmodule // test_card_cycle_gen
